/* File: src/irqep_pkg.sv */
package irqep_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int DW   = 8;
    localparam int AW   = 8;
    localparam int NSRC = 15;
    localparam int NW   = 4;

    typedef logic [NSRC-1:0] irqep_src_t;
    typedef logic [DW-1:0]   irqep_byte_t;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [AW-1:0] ENA_ADDR  = 8'ha8;
    localparam logic [AW-1:0] PRI_ADDR  = 8'hb8;
    localparam logic [AW-1:0] XENA_ADDR = 8'he8;
    localparam logic [AW-1:0] STAT_ADDR = 8'hc0;
    localparam logic [AW-1:0] MASK_ADDR = 8'hc4;

    localparam irqep_byte_t REG_RST    = 8'h00;
    localparam irqep_byte_t ENA_WMASK  = 8'hdf;
    localparam irqep_byte_t PRI_WMASK  = 8'h5f;
    localparam irqep_byte_t XENA_WMASK = 8'h7f;
    localparam irqep_byte_t ST_WMASK  = 8'h0f;

    // enable and priority registers share these bit positions
    localparam int POS_GATE = 7;
    localparam int POS_SER1 = 6;
    localparam int POS_RSVD = 5;
    localparam int POS_SER0 = 4;
    localparam int POS_TMR1 = 3;
    localparam int POS_EXT1 = 2;
    localparam int POS_TMR0 = 1;
    localparam int POS_EXT0 = 0;

    // extended enable (and external extended priority) positions
    localparam int XPOS_VOICE = 6;
    localparam int XPOS_SPI   = 5;
    localparam int XPOS_SLEEP = 4;
    localparam int XPOS_TMR3  = 3;
    localparam int XPOS_AES   = 2;
    localparam int XPOS_TMR2  = 1;
    localparam int XPOS_RADIO = 0;

    // fixed hardware source numbers, lower wins within a level
    localparam int SRC_EXT0  = 0;
    localparam int SRC_TMR0  = 1;
    localparam int SRC_EXT1  = 2;
    localparam int SRC_TMR1  = 3;
    localparam int SRC_SER0  = 4;
    localparam int SRC_SER1  = 7;
    localparam int SRC_RADIO = 8;
    localparam int SRC_TMR2  = 9;
    localparam int SRC_AES   = 10;
    localparam int SRC_TMR3  = 11;
    localparam int SRC_SLEEP = 12;
    localparam int SRC_SPI   = 13;
    localparam int SRC_VOICE = 14;

    // event status bits
    localparam int ST_HI_TAKE = 0;
    localparam int ST_LO_TAKE = 1;
    localparam int ST_PREEMPT = 2;
    localparam int ST_STRAY   = 3;

    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_LO,
        SVC_HI,
        SVC_HI_OVER_LO
    } irqep_svc_t;

    function automatic irqep_src_t low_mask(input logic [NW-1:0] n);
        return irqep_src_t'((16'h0001 << n) - 16'h0001);
    endfunction

    function automatic logic [NW-1:0] lowest_idx(input irqep_src_t v);
        logic [NW-1:0] idx;
        idx = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = NW'(i);
            end
        end
        return idx;
    endfunction

endpackage

/* File: src/irqep_sel_if.sv */
`timescale 1ns/100ps
interface irqep_sel_if;
    irqep_pkg::irqep_src_t pend;
    irqep_pkg::irqep_src_t en;
    irqep_pkg::irqep_src_t prio;
    logic                  blk_hi;
    logic                  blk_lo;
    logic                  vld;
    logic                  hi;
    logic [irqep_pkg::NW-1:0] num;

    modport top (output pend, en, prio, blk_hi, blk_lo,
                 input  vld, hi, num);
    modport arb (input  pend, en, prio, blk_hi, blk_lo,
                 output vld, hi, num);
endinterface

/* File: src/irqep_arb.sv */
`timescale 1ns/100ps
module irqep_arb (
    irqep_sel_if.arb sel
);

    irqep_pkg::irqep_src_t act;
    irqep_pkg::irqep_src_t hi_act;
    irqep_pkg::irqep_src_t lo_act;

    // -------------------------------------------------------------------
    // candidate selection
    // -------------------------------------------------------------------
    assign act    = sel.pend & sel.en;
    // a level already in service shuts out its own level and lower
    assign hi_act = sel.blk_hi ? '0 : (act & sel.prio);
    assign lo_act = sel.blk_lo ? '0 : (act & ~sel.prio);
    assign sel.vld = (|hi_act) | (|lo_act);
    assign sel.hi  = |hi_act;
    assign sel.num = (|hi_act) ? irqep_pkg::lowest_idx(hi_act)
                               : irqep_pkg::lowest_idx(lo_act);

endmodule

/* File: src/irqep_svc.sv */
`timescale 1ns/100ps
module irqep_svc (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic take_i,
    input  wire logic take_hi_i,
    input  wire logic ret_i,
    output logic      blk_hi_o,
    output logic      blk_lo_o,
    output logic      preempt_o,
    output logic      stray_o
);

    irqep_pkg::irqep_svc_t state_ff;
    irqep_pkg::irqep_svc_t nxt_state;

    // -------------------------------------------------------------------
    // in-service level tracking
    // -------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            irqep_pkg::SVC_IDLE: begin
                if (take_i) begin
                    nxt_state = take_hi_i ? irqep_pkg::SVC_HI
                                          : irqep_pkg::SVC_LO;
                end
            end
            irqep_pkg::SVC_LO: begin
                if (take_i && take_hi_i) begin
                    nxt_state = irqep_pkg::SVC_HI_OVER_LO;
                end else if (ret_i) begin
                    nxt_state = irqep_pkg::SVC_IDLE;
                end
            end
            irqep_pkg::SVC_HI: begin
                if (ret_i) begin
                    nxt_state = irqep_pkg::SVC_IDLE;
                end
            end
            irqep_pkg::SVC_HI_OVER_LO: begin
                if (ret_i) begin
                    nxt_state = irqep_pkg::SVC_LO;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= irqep_pkg::SVC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign blk_hi_o  = (state_ff == irqep_pkg::SVC_HI)
                     || (state_ff == irqep_pkg::SVC_HI_OVER_LO);
    assign blk_lo_o  = (state_ff != irqep_pkg::SVC_IDLE);
    assign preempt_o = take_i && take_hi_i
                     && (state_ff == irqep_pkg::SVC_LO);
    assign stray_o   = ret_i && !take_i
                     && (state_ff == irqep_pkg::SVC_IDLE);

endmodule

/* File: src/irqep_top.sv */
`timescale 1ns/100ps
module irqep_top (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [irqep_pkg::AW-1:0]    addr_i,
    input  wire logic [irqep_pkg::DW-1:0]    wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [irqep_pkg::DW-1:0]    rdata_o,
    input  wire logic [irqep_pkg::NSRC-1:0]  pend_i,
    input  wire logic [irqep_pkg::DW-1:0]    ext_prio_i,
    input  wire logic                        ack_i,
    input  wire logic                        reti_i,
    output logic      [irqep_pkg::NSRC-1:0]  src_req_o,
    output logic                             req_o,
    output logic                             req_hi_o,
    output logic      [irqep_pkg::NW-1:0]    req_num_o,
    output logic                             irq_o
);

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    logic                   rst_meta_ff;
    logic                   rst_n;
    irqep_pkg::irqep_byte_t ena_ff;
    irqep_pkg::irqep_byte_t pri_ff;
    irqep_pkg::irqep_byte_t xena_ff;
    irqep_pkg::irqep_byte_t stat_ff;
    irqep_pkg::irqep_byte_t mask_ff;
    irqep_pkg::irqep_byte_t nxt_rdata;
    irqep_pkg::irqep_byte_t evt;
    irqep_pkg::irqep_src_t  en_vec;
    irqep_pkg::irqep_src_t  prio_vec;
    irqep_pkg::irqep_src_t  hi_pend_ff;
    logic                   take;
    logic                   blk_hi;
    logic                   blk_lo;
    logic                   preempt;
    logic                   stray;
    logic                   gate;

    irqep_sel_if sel ();

    // -------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------
    // release is synchronised so that every flop leaves reset together
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // -------------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ena_ff <= irqep_pkg::REG_RST;
        end else if (wr_i && addr_i == irqep_pkg::ENA_ADDR) begin
            ena_ff <= wdata_i & irqep_pkg::ENA_WMASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pri_ff <= irqep_pkg::REG_RST;
        end else if (wr_i && addr_i == irqep_pkg::PRI_ADDR) begin
            pri_ff <= wdata_i & irqep_pkg::PRI_WMASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xena_ff <= irqep_pkg::REG_RST;
        end else if (wr_i && addr_i == irqep_pkg::XENA_ADDR) begin
            xena_ff <= wdata_i & irqep_pkg::XENA_WMASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= irqep_pkg::REG_RST;
        end else if (wr_i && addr_i == irqep_pkg::MASK_ADDR) begin
            mask_ff <= wdata_i & irqep_pkg::ST_WMASK;
        end
    end

    // -------------------------------------------------------------------
    // enable and priority vectors by source number
    // -------------------------------------------------------------------
    assign gate = ena_ff[irqep_pkg::POS_GATE];

    always_comb begin
        en_vec = '0;
        en_vec[irqep_pkg::SRC_EXT0]  = ena_ff[irqep_pkg::POS_EXT0];
        en_vec[irqep_pkg::SRC_TMR0]  = ena_ff[irqep_pkg::POS_TMR0];
        en_vec[irqep_pkg::SRC_EXT1]  = ena_ff[irqep_pkg::POS_EXT1];
        en_vec[irqep_pkg::SRC_TMR1]  = ena_ff[irqep_pkg::POS_TMR1];
        en_vec[irqep_pkg::SRC_SER0]  = ena_ff[irqep_pkg::POS_SER0];
        en_vec[irqep_pkg::SRC_SER1]  = ena_ff[irqep_pkg::POS_SER1];
        en_vec[irqep_pkg::SRC_RADIO] = xena_ff[irqep_pkg::XPOS_RADIO];
        en_vec[irqep_pkg::SRC_TMR2]  = xena_ff[irqep_pkg::XPOS_TMR2];
        en_vec[irqep_pkg::SRC_AES]   = xena_ff[irqep_pkg::XPOS_AES];
        en_vec[irqep_pkg::SRC_TMR3]  = xena_ff[irqep_pkg::XPOS_TMR3];
        en_vec[irqep_pkg::SRC_SLEEP] = xena_ff[irqep_pkg::XPOS_SLEEP];
        en_vec[irqep_pkg::SRC_SPI]   = xena_ff[irqep_pkg::XPOS_SPI];
        en_vec[irqep_pkg::SRC_VOICE] = xena_ff[irqep_pkg::XPOS_VOICE];
        // the gate covers standard and extended sources alike
        if (!gate) begin
            en_vec = '0;
        end
    end

    // extended priority bits are held outside this block
    always_comb begin
        prio_vec = '0;
        prio_vec[irqep_pkg::SRC_EXT0]  = pri_ff[irqep_pkg::POS_EXT0];
        prio_vec[irqep_pkg::SRC_TMR0]  = pri_ff[irqep_pkg::POS_TMR0];
        prio_vec[irqep_pkg::SRC_EXT1]  = pri_ff[irqep_pkg::POS_EXT1];
        prio_vec[irqep_pkg::SRC_TMR1]  = pri_ff[irqep_pkg::POS_TMR1];
        prio_vec[irqep_pkg::SRC_SER0]  = pri_ff[irqep_pkg::POS_SER0];
        prio_vec[irqep_pkg::SRC_SER1]  = pri_ff[irqep_pkg::POS_SER1];
        prio_vec[irqep_pkg::SRC_RADIO] = ext_prio_i[irqep_pkg::XPOS_RADIO];
        prio_vec[irqep_pkg::SRC_TMR2]  = ext_prio_i[irqep_pkg::XPOS_TMR2];
        prio_vec[irqep_pkg::SRC_AES]   = ext_prio_i[irqep_pkg::XPOS_AES];
        prio_vec[irqep_pkg::SRC_TMR3]  = ext_prio_i[irqep_pkg::XPOS_TMR3];
        prio_vec[irqep_pkg::SRC_SLEEP] = ext_prio_i[irqep_pkg::XPOS_SLEEP];
        prio_vec[irqep_pkg::SRC_SPI]   = ext_prio_i[irqep_pkg::XPOS_SPI];
        prio_vec[irqep_pkg::SRC_VOICE] = ext_prio_i[irqep_pkg::XPOS_VOICE];
    end

    // -------------------------------------------------------------------
    // arbitration and service tracking
    // -------------------------------------------------------------------
    assign sel.pend   = pend_i;
    assign sel.en     = en_vec;
    assign sel.prio   = prio_vec;
    assign sel.blk_hi = blk_hi;
    assign sel.blk_lo = blk_lo;

    irqep_arb u_arb (
        .sel (sel)
    );

    // an acknowledge only counts against a request actually on show
    assign take = ack_i && req_o;

    irqep_svc u_svc (
        .clk_i     (clk_i),
        .rstn_i    (rst_n),
        .take_i    (take),
        .take_hi_i (req_hi_o),
        .ret_i     (reti_i),
        .blk_hi_o  (blk_hi),
        .blk_lo_o  (blk_lo),
        .preempt_o (preempt),
        .stray_o   (stray)
    );

    // -------------------------------------------------------------------
    // requests to the core
    // -------------------------------------------------------------------
    // request drops on the acknowledge edge; the service state only
    // reaches the arbiter one cycle later, so a stale vector is never
    // shown twice
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            req_o     <= 1'b0;
            req_hi_o  <= 1'b0;
            req_num_o <= '0;
        end else begin
            req_o     <= sel.vld && !take;
            req_hi_o  <= sel.hi;
            req_num_o <= sel.num;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_req_o <= '0;
        end else begin
            src_req_o <= pend_i & en_vec;
        end
    end

    // only the assertions read this copy
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hi_pend_ff <= '0;
        end else begin
            hi_pend_ff <= pend_i & en_vec & prio_vec;
        end
    end

    // -------------------------------------------------------------------
    // event status, mask and interrupt line
    // -------------------------------------------------------------------
    always_comb begin
        evt = '0;
        evt[irqep_pkg::ST_HI_TAKE] = take && req_hi_o;
        evt[irqep_pkg::ST_LO_TAKE] = take && !req_hi_o;
        evt[irqep_pkg::ST_PREEMPT] = preempt;
        evt[irqep_pkg::ST_STRAY]   = stray;
    end

    // an event landing on the clearing read survives it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= irqep_pkg::REG_RST;
        end else if (rd_i && addr_i == irqep_pkg::STAT_ADDR) begin
            stat_ff <= evt;
        end else begin
            stat_ff <= stat_ff | evt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_ff & mask_ff);
        end
    end

    // -------------------------------------------------------------------
    // register reads
    // -------------------------------------------------------------------
    always_comb begin
        nxt_rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                irqep_pkg::ENA_ADDR:  nxt_rdata = ena_ff;
                irqep_pkg::PRI_ADDR:  nxt_rdata = pri_ff;
                irqep_pkg::XENA_ADDR: nxt_rdata = xena_ff;
                irqep_pkg::STAT_ADDR: nxt_rdata = stat_ff;
                irqep_pkg::MASK_ADDR: nxt_rdata = mask_ff;
                default:              nxt_rdata = '0;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= nxt_rdata;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (!rst_n);

    chk_gate_no_src: assert property (
        !gate |=> (src_req_o == '0)
    ) else $error("source request seen with global gate closed");

    chk_gate_no_req: assert property (
        !gate ##1 !gate |=> !req_o
    ) else $error("core request raised with global gate closed");

    chk_req_source_on: assert property (
        req_o |-> src_req_o[req_num_o]
    ) else $error("presented vector belongs to no live source");

    chk_std_enable: assert property (
        !ena_ff[irqep_pkg::POS_TMR0] |=> !src_req_o[irqep_pkg::SRC_TMR0]
    ) else $error("timer0 request with its enable clear");

    chk_ext_enable: assert property (
        !xena_ff[irqep_pkg::XPOS_AES] |=> !src_req_o[irqep_pkg::SRC_AES]
    ) else $error("aes request with its enable clear");

    chk_reserved_bits: assert property (
        !ena_ff[irqep_pkg::POS_RSVD] && !pri_ff[irqep_pkg::POS_GATE]
        && !pri_ff[irqep_pkg::POS_RSVD] && !xena_ff[irqep_pkg::POS_GATE]
    ) else $error("reserved register bit is set");

    chk_hi_level_flag: assert property (
        req_o |-> (req_hi_o == hi_pend_ff[req_num_o])
    ) else $error("request level does not match its priority bit");

    chk_lo_lowest_num: assert property (
        req_o && !req_hi_o
        |-> ((src_req_o & irqep_pkg::low_mask(req_num_o)) == '0)
    ) else $error("lower numbered source passed over");

    chk_hi_before_lo: assert property (
        req_o && !req_hi_o |-> (hi_pend_ff == '0)
    ) else $error("low level shown while high level pends");

    chk_preempt_flag: assert property (
        take && req_hi_o && blk_lo && !blk_hi
        |=> blk_hi && blk_lo && stat_ff[irqep_pkg::ST_PREEMPT]
    ) else $error("preemption of a low routine not recorded");

    chk_hi_busy_quiet: assert property (
        blk_hi |=> !req_o
    ) else $error("request shown while a high routine runs");

    chk_lo_busy_hi: assert property (
        blk_lo |=> !req_o || req_hi_o
    ) else $error("low request shown while a low routine runs");

    chk_req_drop_ack: assert property (
        take |=> !req_o
    ) else $error("request still shown after acknowledge");

    chk_irq_line: assert property (
        (stat_ff & mask_ff) != '0 |=> irq_o
    ) else $error("interrupt line low with unmasked event");

    chk_read_clear: assert property (
        rd_i && addr_i == irqep_pkg::STAT_ADDR && evt == '0
        |=> stat_ff == '0 && rdata_o == $past(stat_ff)
    ) else $error("status read did not return and clear");

    // set wins over the clearing read
    chk_evt_survives: assert property (
        rd_i && addr_i == irqep_pkg::STAT_ADDR && evt != '0
        |=> stat_ff == $past(evt)
    ) else $error("event lost on the clearing status read");

endmodule

/* File: verification/irqep_core_model.sv */
`timescale 1ns/100ps
module irqep_core_model (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       req_i,
    input  wire logic       auto_i,
    input  wire logic [3:0] lat_i,
    output logic            ack_o
);
    // ---------------------------------------------------------------
    // acknowledge after lat_i + 1 cycles of a standing request
    // ---------------------------------------------------------------
    logic [3:0] wait_ff;

    // one pulse per shown request: the pulse clears the count, so a
    // request that lingers one more cycle is never taken twice
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_o   <= 1'b0;
            wait_ff <= 4'h0;
        end else begin
            ack_o <= 1'b0;
            if (ack_o) begin
                wait_ff <= 4'h0;
            end else if (req_i && auto_i) begin
                if (wait_ff == lat_i) begin
                    ack_o <= 1'b1;
                end else begin
                    wait_ff <= wait_ff + 4'h1;
                end
            end else begin
                wait_ff <= 4'h0;
            end
        end
    end
endmodule

/* File: verification/tb_irqep_top.sv */
`timescale 1ns/100ps
module tb_irqep_top;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [14:0] pend_i = 15'h0000;
    logic [7:0]  ext_prio_i = 8'h00;
    logic        ack_i;
    logic        reti_i = 1'b0;
    logic [14:0] src_req_o;
    logic        req_o;
    logic        req_hi_o;
    logic [3:0]  req_num_o;
    logic        irq_o;
    logic        auto = 1'b0;
    logic [3:0]  lat = 4'h0;
    int          failures = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          bt[13] = '{6, 4, 3, 2, 1, 0, 6, 5, 4, 3, 2, 1, 0};
    int          sr[13] = '{7, 4, 3, 2, 1, 0, 14, 13, 12, 11, 10, 9, 8};

    always #12.5 clk_i = ~clk_i;

    irqep_top irqep_top_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pend_i(pend_i), .ext_prio_i(ext_prio_i),
        .ack_i(ack_i), .reti_i(reti_i), .src_req_o(src_req_o),
        .req_o(req_o), .req_hi_o(req_hi_o), .req_num_o(req_num_o),
        .irq_o(irq_o));
    irqep_core_model irqep_core_model_inst (.clk_i(clk_i),
        .rstn_i(rstn_i), .req_i(req_o), .auto_i(auto), .lat_i(lat),
        .ack_o(ack_i));

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // rdata_o stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk("rdata", {8'h00, rdata_o}, {8'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic ret();
        @(posedge clk_i);
        reti_i <= 1'b1;
        @(posedge clk_i);
        reti_i <= 1'b0;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        cyc(3);
        rd(irqep_pkg::ENA_ADDR, 8'h00);
        rd(irqep_pkg::PRI_ADDR, 8'h00);
        rd(irqep_pkg::XENA_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        wr(irqep_pkg::ENA_ADDR, 8'hff);
        wr(irqep_pkg::PRI_ADDR, 8'hff);
        wr(irqep_pkg::XENA_ADDR, 8'hff);
        rd(irqep_pkg::ENA_ADDR, 8'hdf);
        rd(irqep_pkg::PRI_ADDR, 8'h5f);
        rd(irqep_pkg::XENA_ADDR, 8'h7f);
        wr(irqep_pkg::PRI_ADDR, 8'h00);
        $display("test registers done");
        @(posedge clk_i);
        pend_i <= 15'h7fff;
        cyc(3);
        chk("src_all", {1'b0, src_req_o}, 16'h7f9f);
        wr(irqep_pkg::ENA_ADDR, 8'h7f);
        cyc(3);
        chk("src_gate", {1'b0, src_req_o}, 16'h0000);
        chk("req_gate", {15'h0, req_o}, 16'h0000);
        for (int i = 0; i < 13; i++) begin
            wr(irqep_pkg::ENA_ADDR,
               i < 6 ? 8'h80 | (8'h01 << bt[i]) : 8'h80);
            wr(irqep_pkg::XENA_ADDR, i < 6 ? 8'h00 : 8'h01 << bt[i]);
            cyc(2);
            chk("src_one", {1'b0, src_req_o}, 16'h0001 << sr[i]);
        end
        wr(irqep_pkg::ENA_ADDR, 8'h00);
        cyc(2);
        chk("src_ext_gate", {1'b0, src_req_o}, 16'h0000);
        $display("test enables done");
        @(posedge clk_i);
        pend_i <= 15'h000a;
        wr(irqep_pkg::ENA_ADDR, 8'hff);
        cyc(3);
        chk("num_lo", {12'h0, req_num_o}, 16'h0001);
        chk("hi_lo", {15'h0, req_hi_o}, 16'h0000);
        wr(irqep_pkg::PRI_ADDR, 8'h08);
        cyc(3);
        chk("num_hi", {12'h0, req_num_o}, 16'h0003);
        chk("hi_hi", {15'h0, req_hi_o}, 16'h0001);
        @(posedge clk_i);
        pend_i     <= 15'h0300;
        ext_prio_i <= 8'h02;
        wr(irqep_pkg::XENA_ADDR, 8'h03);
        cyc(3);
        chk("num_ext", {12'h0, req_num_o}, 16'h0009);
        chk("hi_ext", {15'h0, req_hi_o}, 16'h0001);
        $display("test priority done");
        @(posedge clk_i);
        pend_i     <= 15'h0001;
        ext_prio_i <= 8'h00;
        wr(irqep_pkg::MASK_ADDR, 8'h07);
        auto <= 1'b1;
        cyc(5);
        chk("req_in_lo", {15'h0, req_o}, 16'h0000);
        @(posedge clk_i);
        lat    <= 4'h3;
        pend_i <= 15'h0009;
        cyc(10);
        chk("req_in_hi", {15'h0, req_o}, 16'h0000);
        @(posedge clk_i);
        pend_i <= 15'h0000;
        cyc(2);
        chk("irq_set", {15'h0, irq_o}, 16'h0001);
        rd(irqep_pkg::STAT_ADDR, 8'h07);
        cyc(2);
        chk("irq_clr", {15'h0, irq_o}, 16'h0000);
        ret();
        ret();
        // stray return lands on the clearing read, its event must stay
        @(posedge clk_i);
        addr_i <= irqep_pkg::STAT_ADDR;
        rd_i   <= 1'b1;
        reti_i <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        reti_i <= 1'b0;
        #1;
        chk("rdata_clr", {8'h00, rdata_o}, 16'h0000);
        cyc(3);
        chk("irq_masked", {15'h0, irq_o}, 16'h0000);
        rd(irqep_pkg::STAT_ADDR, 8'h08);
        rd(irqep_pkg::STAT_ADDR, 8'h00);
        $display("test service done");
        complete_run();
    end
endmodule
